// ### src/motor_alarm_supervisor.sv
// Alarm and warning supervisor with Avalon-MM register slave
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module motor_alarm_supervisor #(
  parameter int OVER_CYC = motor_alarm_pkg::OVER_CYC,
  parameter int ASSIST_CYC = motor_alarm_pkg::ASSIST_CYC,
  parameter int MS_CYC = motor_alarm_pkg::MS_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [6:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Control inputs from the outside controller
  input wire logic i_forward_run_input,
  input wire logic i_backward_run_input,
  input wire logic i_fault_clear_input,
  input wire logic i_outside_fault_input,
  input wire logic i_free_input,
  // Motor and storage sensing
  input wire logic i_thermal_open,
  input wire logic i_tach_pulse,
  input wire logic i_nv_error,
  // Motor drive and brake
  output logic o_drive_en,
  output logic o_drive_dir,
  output logic o_brake_release,
  output logic o_brake_assist,
  // Alarm and signal outputs
  output logic o_fault_ok,
  output logic o_alarm_lamp,
  output logic [7:0] o_alarm_code,
  output logic o_caution_output,
  output logic o_thermal_trip_output
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] prev;
    motor_alarm_pkg::phase_t phase;
    logic [1:0] wake_cnt;
    logic [5:0] alarm;
    logic [7:0] ctrl;
    logic [15:0] lock_ms;
    logic warn;
    logic warn_seen;
    logic wait_req;
    logic [31:0] rdata;
    logic drive;
    logic dir;
    logic brake_rel;
    logic assist;
    logic fault_ok;
    logic lamp;
    logic [7:0] code;
    logic caution;
    logic thermal;
  } sup_t;

  sup_t st_r;
  sup_t st_nxt;

  // Alarm history, kept apart from the state so power-up leaves it alone
  logic [7:0] hist_mem [motor_alarm_pkg::HIST_DEPTH];

  logic [7:0] pin_vec;
  logic meter_over;
  logic meter_assist;
  logic [15:0] stall_ms;
  logic run_any;
  logic run_one;
  logic req;
  logic acc;
  logic [5:0] set_v;
  logic [5:0] clr_v;
  logic [5:0] new_v;
  logic push_en;
  logic hist_clr;
  logic [7:0] push_code;
  logic clr_edge;
  logic [3:0] hist_idx;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Highest-priority flagged alarm gives the shown code
  function automatic logic [7:0] code_of(input logic [5:0] m);
    logic [7:0] c;
    c = motor_alarm_pkg::CODE_NONE;
    if (m[motor_alarm_pkg::AL_POR]) begin
      c = motor_alarm_pkg::CODE_POR;
    end
    if (m[motor_alarm_pkg::AL_EXT]) begin
      c = motor_alarm_pkg::CODE_EXT;
    end
    if (m[motor_alarm_pkg::AL_LOCK]) begin
      c = motor_alarm_pkg::CODE_LOCK;
    end
    if (m[motor_alarm_pkg::AL_OVSP]) begin
      c = motor_alarm_pkg::CODE_OVSP;
    end
    if (m[motor_alarm_pkg::AL_HEAT]) begin
      c = motor_alarm_pkg::CODE_HEAT;
    end
    if (m[motor_alarm_pkg::AL_NV]) begin
      c = motor_alarm_pkg::CODE_NV;
    end
    return c;
  endfunction : code_of

  // ------------------------------------------------------------------
  // Pins and speed meter
  // ------------------------------------------------------------------
  // All pins are asynchronous to the clock; they enter via s1 then s2
  assign pin_vec = {i_nv_error, i_free_input, i_tach_pulse, i_thermal_open,
                    i_outside_fault_input, i_fault_clear_input,
                    i_backward_run_input, i_forward_run_input};

  shaft_speed_meter #(
    .OVER_CYC(OVER_CYC),
    .ASSIST_CYC(ASSIST_CYC),
    .MS_CYC(MS_CYC)
  ) u_meter (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_tach(st_r.s2[motor_alarm_pkg::IN_TACH]),
    .i_running(st_r.drive),
    .o_over(meter_over),
    .o_assist(meter_assist),
    .o_stall_ms(stall_ms)
  );

  // Run decode from synchronised levels
  assign run_any = st_r.s2[motor_alarm_pkg::IN_FORWARD] | st_r.s2[motor_alarm_pkg::IN_BWD];
  assign run_one = st_r.s2[motor_alarm_pkg::IN_FORWARD] ^ st_r.s2[motor_alarm_pkg::IN_BWD];

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  // Access completes on the second edge: one wait cycle, then accept
  assign req = i_avs_read | i_avs_write;
  assign acc = req & ~st_r.wait_req;
  assign hist_idx = 4'(i_avs_address[6:2] - motor_alarm_pkg::ADDR_HIST[6:2]);

  // ------------------------------------------------------------------
  // Alarm sources and clears
  // ------------------------------------------------------------------
  always_comb begin
    set_v = '0;
    clr_v = '0;
    // Sources only act once the input pipes are valid
    if (st_r.phase == motor_alarm_pkg::PH_RUN) begin
      set_v[motor_alarm_pkg::AL_HEAT] =
        st_r.s2[motor_alarm_pkg::IN_HEAT];
      set_v[motor_alarm_pkg::AL_LOCK] = st_r.drive &
        (stall_ms > st_r.lock_ms);
      set_v[motor_alarm_pkg::AL_OVSP] = meter_over;
      set_v[motor_alarm_pkg::AL_NV] = st_r.s2[motor_alarm_pkg::IN_NV];
      set_v[motor_alarm_pkg::AL_EXT] = st_r.ctrl[motor_alarm_pkg::CTRL_EXT_ASG] &
        ~st_r.s2[motor_alarm_pkg::IN_EXT];
    end
    // Power-up run check happens once, at the end of the wake phase
    if (st_r.phase == motor_alarm_pkg::PH_WAKE && st_r.wake_cnt == motor_alarm_pkg::WAKE_CYC) begin
      set_v[motor_alarm_pkg::AL_POR] = st_r.ctrl[motor_alarm_pkg::CTRL_POR_EN] &
        run_any;
    end
    // Run alarm from power-up leaves as soon as both runs are off
    if (!run_any) begin
      clr_v[motor_alarm_pkg::AL_POR] = 1'b1;
    end
    // Edge of fault clear, locked out while a run input is on
    clr_edge = st_r.s2[motor_alarm_pkg::IN_CLR] & ~st_r.prev[motor_alarm_pkg::IN_CLR] &
      ~run_any;
    if (clr_edge) begin
      clr_v = clr_v | ~(6'h1 << motor_alarm_pkg::AL_NV);
    end
    // Panel reset clears everything, storage error included
    if (acc && i_avs_write && i_avs_address == motor_alarm_pkg::ADDR_CMD &&
        i_avs_byteenable[0] && i_avs_writedata[motor_alarm_pkg::CMD_PANEL_RST]) begin
      clr_v = '1;
    end
    new_v = set_v & ~st_r.alarm;
  end

  // ------------------------------------------------------------------
  // History control
  // ------------------------------------------------------------------
  // Only one entry per cycle; simultaneous alarms log the top one
  assign push_en = |new_v;
  assign push_code = code_of(new_v);
  assign hist_clr = acc & i_avs_write & (i_avs_address == motor_alarm_pkg::ADDR_CMD) &
    i_avs_byteenable[0] & i_avs_writedata[motor_alarm_pkg::CMD_HIST_CLR];

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    logic trip;
    logic [31:0] rd;
    trip = 1'b0;
    rd = 32'h0;
    st_nxt = st_r;

    // Two-stage pin synchroniser and edge history
    st_nxt.s1 = pin_vec;
    st_nxt.s2 = st_r.s1;
    st_nxt.prev = st_r.s2;

    // Wake phase waits for the synchroniser to fill
    unique case (st_r.phase)
      motor_alarm_pkg::PH_WAKE: begin
        if (st_r.wake_cnt == motor_alarm_pkg::WAKE_CYC) begin
          st_nxt.phase = motor_alarm_pkg::PH_RUN;
        end else begin
          st_nxt.wake_cnt = st_r.wake_cnt + 2'h1;
        end
      end
      motor_alarm_pkg::PH_RUN: begin
        st_nxt.wake_cnt = st_r.wake_cnt;
      end
    endcase

    // Latch; a source still present wins over its clear
    st_nxt.alarm = (st_r.alarm & ~clr_v) | set_v;
    trip = |st_nxt.alarm;

    // Warnings: lock warning while driven; sticky copy lost at power-down
    st_nxt.warn = st_r.drive &
      (stall_ms >= 16'(motor_alarm_pkg::LOCK_WARN_MS));
    st_nxt.warn_seen = st_r.warn_seen | st_r.warn;

    // Drive stops on a trip, on both runs, or with the brake freed.
    // Held off in the wake phase so a run input never starts the motor early.
    st_nxt.drive = (st_r.phase == motor_alarm_pkg::PH_RUN) & run_one & ~trip &
      ~st_r.s2[motor_alarm_pkg::IN_FREE];
    st_nxt.dir = st_r.s2[motor_alarm_pkg::IN_BWD];
    // Brake holds on a trip; no release request passes then
    st_nxt.brake_rel = ~trip & (st_r.s2[motor_alarm_pkg::IN_FREE] |
      (st_r.ctrl[motor_alarm_pkg::CTRL_PANEL_REL] & ~run_any));
    // Braking current whenever fast, also when the load pushes the shaft
    st_nxt.assist = meter_assist;

    // Alarm indication, same edge as the drive cut
    st_nxt.fault_ok = ~trip;
    st_nxt.lamp = trip;
    st_nxt.code = code_of(st_nxt.alarm);

    // Assignable outputs reach their pins only when assigned
    st_nxt.caution = st_r.ctrl[motor_alarm_pkg::CTRL_CAU_ASG] & st_r.warn;
    st_nxt.thermal = st_r.ctrl[motor_alarm_pkg::CTRL_TH_ASG] &
      st_r.s2[motor_alarm_pkg::IN_HEAT];

    // Wait state: high at idle, low for exactly the accepting cycle
    st_nxt.wait_req = ~(req & st_r.wait_req);

    // Register writes, byte lanes honoured
    if (acc && i_avs_write) begin
      if (i_avs_address == motor_alarm_pkg::ADDR_CTRL && i_avs_byteenable[0]) begin
        st_nxt.ctrl = i_avs_writedata[7:0];
      end
      if (i_avs_address == motor_alarm_pkg::ADDR_LOCK) begin
        if (i_avs_byteenable[0]) begin
          st_nxt.lock_ms[7:0] = i_avs_writedata[7:0];
        end
        if (i_avs_byteenable[1]) begin
          st_nxt.lock_ms[15:8] = i_avs_writedata[15:8];
        end
      end
    end

    // Read data prepared during the wait cycle, stable at acceptance
    if (req && st_r.wait_req) begin
      if (i_avs_address == motor_alarm_pkg::ADDR_CTRL) begin
        rd[7:0] = st_r.ctrl;
      end else if (i_avs_address == motor_alarm_pkg::ADDR_LOCK) begin
        rd[15:0] = st_r.lock_ms;
      end else if (i_avs_address == motor_alarm_pkg::ADDR_STAT) begin
        rd[5:0] = st_r.alarm;
        rd[motor_alarm_pkg::ST_WARN] = st_r.warn;
        rd[motor_alarm_pkg::ST_WSEEN] = st_r.warn_seen;
        rd[motor_alarm_pkg::ST_TRIP] = st_r.lamp;
        rd[motor_alarm_pkg::ST_CODE +: 8] = st_r.code;
      end else if (i_avs_address >= motor_alarm_pkg::ADDR_HIST &&
                   hist_idx < 4'(motor_alarm_pkg::HIST_DEPTH) &&
                   i_avs_address[1:0] == 2'h0) begin
        rd[7:0] = hist_mem[hist_idx];
      end
      st_nxt.rdata = rd;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Whole state except the alarm history in one register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '{s1: 8'h00, s2: 8'h00, prev: 8'h00,
                phase: motor_alarm_pkg::PH_WAKE, wake_cnt: 2'h0,
                alarm: 6'h00, ctrl: motor_alarm_pkg::CTRL_RST,
                lock_ms: motor_alarm_pkg::LOCK_MS_RST,
                warn: 1'b0, warn_seen: 1'b0, wait_req: 1'b1,
                rdata: 32'h0, drive: 1'b0, dir: 1'b0, brake_rel: 1'b0,
                assist: 1'b0, fault_ok: 1'b1, lamp: 1'b0,
                code: motor_alarm_pkg::CODE_NONE, caution: 1'b0,
                thermal: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // History shift register, newest at entry 0; zero marks an empty slot.
  // No reset: contents model storage that outlives control power.
  always_ff @(posedge i_ref_clk) begin
    if (hist_clr) begin
      for (int i = 0; i < motor_alarm_pkg::HIST_DEPTH; i++) begin
        hist_mem[i] <= 8'h00;
      end
      // An alarm rising in the clearing cycle is still logged
      if (push_en) begin
        hist_mem[0] <= push_code;
      end
    end else if (push_en) begin
      for (int i = motor_alarm_pkg::HIST_DEPTH - 1; i > 0; i--) begin
        hist_mem[i] <= hist_mem[i - 1];
      end
      hist_mem[0] <= push_code;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ------------------------------------------------------------------
  assign o_avs_readdata = st_r.rdata;
  assign o_avs_waitrequest = st_r.wait_req;
  assign o_drive_en = st_r.drive;
  assign o_drive_dir = st_r.dir;
  assign o_brake_release = st_r.brake_rel;
  assign o_brake_assist = st_r.assist;
  assign o_fault_ok = st_r.fault_ok;
  assign o_alarm_lamp = st_r.lamp;
  assign o_alarm_code = st_r.code;
  assign o_caution_output = st_r.caution;
  assign o_thermal_trip_output = st_r.thermal;

endmodule : motor_alarm_supervisor

// ### src/motor_alarm_pkg.sv
// Constants, field layouts and types shared by the motor alarm supervisor
package motor_alarm_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int PULSES_PER_REV = 12;
  localparam int OVERSPEED_RPM = 2300;
  localparam int ASSIST_RPM = 2100;
  localparam int LOCK_WARN_MS = 1000;
  // Tach period below these counts means the speed is above the limit
  localparam int OVER_CYC = (CLK_HZ * 60) / (PULSES_PER_REV * OVERSPEED_RPM);
  localparam int ASSIST_CYC = (CLK_HZ * 60) / (PULSES_PER_REV * ASSIST_RPM);
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam logic [1:0] WAKE_CYC = 2'h3;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [6:0] ADDR_CTRL = 7'h00;
  localparam logic [6:0] ADDR_LOCK = 7'h04;
  localparam logic [6:0] ADDR_CMD = 7'h08;
  localparam logic [6:0] ADDR_STAT = 7'h0C;
  localparam logic [6:0] ADDR_HIST = 7'h20;
  localparam int HIST_DEPTH = 9;

  // CTRL fields and reset value
  localparam int CTRL_POR_EN = 0;
  localparam int CTRL_EXT_ASG = 1;
  localparam int CTRL_CAU_ASG = 2;
  localparam int CTRL_TH_ASG = 3;
  localparam int CTRL_PANEL_REL = 4;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [15:0] LOCK_MS_RST = 16'h07D0;

  // CMD fields (write one to act)
  localparam int CMD_PANEL_RST = 0;
  localparam int CMD_HIST_CLR = 1;

  // STATUS fields
  localparam int ST_WARN = 8;
  localparam int ST_WSEEN = 9;
  localparam int ST_TRIP = 10;
  localparam int ST_CODE = 16;

  // ------------------------------------------------------------------
  // Alarm flags and display codes
  // ------------------------------------------------------------------
  localparam int AL_HEAT = 0;
  localparam int AL_LOCK = 1;
  localparam int AL_OVSP = 2;
  localparam int AL_NV = 3;
  localparam int AL_POR = 4;
  localparam int AL_EXT = 5;
  localparam int AL_NUM = 6;
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_HEAT = 8'h26;
  localparam logic [7:0] CODE_LOCK = 8'h30;
  localparam logic [7:0] CODE_OVSP = 8'h31;
  localparam logic [7:0] CODE_NV = 8'h41;
  localparam logic [7:0] CODE_POR = 8'h45;
  localparam logic [7:0] CODE_EXT = 8'h6E;

  // Synchronised input vector positions
  localparam int IN_FORWARD = 0;
  localparam int IN_BWD = 1;
  localparam int IN_CLR = 2;
  localparam int IN_EXT = 3;
  localparam int IN_HEAT = 4;
  localparam int IN_TACH = 5;
  localparam int IN_FREE = 6;
  localparam int IN_NV = 7;

  typedef enum logic {PH_WAKE, PH_RUN} phase_t;

endpackage : motor_alarm_pkg

// ### src/shaft_speed_meter.sv
// Tach period meter: overspeed, brake assist and stall time in ms
`timescale 1ns/1ps
module shaft_speed_meter #(
  parameter int OVER_CYC = motor_alarm_pkg::OVER_CYC,
  parameter int ASSIST_CYC = motor_alarm_pkg::ASSIST_CYC,
  parameter int MS_CYC = motor_alarm_pkg::MS_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Synchronised tach level and drive state
  input wire logic i_tach,
  input wire logic i_running,
  // Results
  output logic o_over,
  output logic o_assist,
  output logic [15:0] o_stall_ms
);

  typedef struct packed {
    logic prev;
    logic seen;
    logic [19:0] per;
    logic [19:0] pre;
    logic [15:0] stall;
    logic over;
    logic assist;
  } meter_t;

  meter_t r_r;
  meter_t r_nxt;
  logic edge_seen;

  assign edge_seen = i_tach & ~r_r.prev;

  // Period measured edge to edge; a missing edge lets speed fall to zero
  always_comb begin
    r_nxt = r_r;
    r_nxt.prev = i_tach;
    if (r_r.per != 20'hFFFFF) begin
      r_nxt.per = r_r.per + 20'h1;
    end
    if (edge_seen) begin
      r_nxt.per = 20'h1;
      r_nxt.seen = 1'b1;
      r_nxt.over = r_r.seen & (r_r.per < 20'(OVER_CYC));
      r_nxt.assist = r_r.seen & (r_r.per < 20'(ASSIST_CYC));
    end else if (r_r.per >= 20'(ASSIST_CYC)) begin
      r_nxt.over = 1'b0;
      r_nxt.assist = 1'b0;
    end
    // Stall time counts only while driven and no edge arrives
    if (!i_running || edge_seen) begin
      r_nxt.pre = 20'h0;
      r_nxt.stall = 16'h0;
    end else if (r_r.pre == 20'(MS_CYC - 1)) begin
      r_nxt.pre = 20'h0;
      if (r_r.stall != 16'hFFFF) begin
        r_nxt.stall = r_r.stall + 16'h1;
      end
    end else begin
      r_nxt.pre = r_r.pre + 20'h1;
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign o_over = r_r.over;
  assign o_assist = r_r.assist;
  assign o_stall_ms = r_r.stall;

endmodule : shaft_speed_meter

// ### sim/motor_alarm_asserts.sv
// Port checker for the motor alarm supervisor
`timescale 1ns/1ps
module motor_alarm_asserts (
  // Clock, reset and watched ports
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_forward_run_input,
  input wire logic i_thermal_open,
  input wire logic o_drive_en,
  input wire logic o_brake_release,
  input wire logic o_fault_ok,
  input wire logic o_alarm_lamp,
  input wire logic [7:0] o_alarm_code,
  input wire logic o_thermal_trip_output
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ------------------------------------------------------------------
  // Trip response and latching
  // ------------------------------------------------------------------
  property p_trip_stop; o_alarm_lamp |-> !o_drive_en; endproperty
  a_trip_stop: assert property (p_trip_stop) else $error("drive on in alarm");
  property p_no_release; o_alarm_lamp |-> !o_brake_release; endproperty
  a_no_release: assert property (p_no_release) else $error("brake freed in alarm");
  property p_show; o_fault_ok != o_alarm_lamp && ((o_alarm_code != 8'h00) == o_alarm_lamp);
  endproperty
  a_show: assert property (p_show) else $error("indicators disagree");
  property p_heat; $rose(i_thermal_open) |-> ##3 o_alarm_lamp; endproperty
  a_heat: assert property (p_heat) else $error("no overheat trip");
  property p_th_off; $fell(i_thermal_open) |-> ##3 !o_thermal_trip_output; endproperty
  a_th_off: assert property (p_th_off) else $error("thermal out stuck");
  // Running blocks the clear input, so only a bus write could drop the lamp
  property p_run_hold; (o_alarm_lamp && i_forward_run_input && !i_avs_write) [*4] |=> o_alarm_lamp;
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("alarm lost while run");
  property p_nv_hold; (o_alarm_code == motor_alarm_pkg::CODE_NV && !i_avs_write) [*4] |=>
    o_alarm_code == motor_alarm_pkg::CODE_NV; endproperty
  a_nv_hold: assert property (p_nv_hold) else $error("storage alarm lost");
  property p_power; $fell(i_rst) |-> o_fault_ok && !o_alarm_lamp; endproperty
  a_power: assert property (p_power) else $error("alarm after power up");
  // Drive stays off until the power-up run check has been made
  property p_wake_still; $fell(i_rst) |-> !o_drive_en [*4]; endproperty
  a_wake_still: assert property (p_wake_still) else $error("drive during wake");
  property p_wait; $rose(i_avs_read || i_avs_write) |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer timing");
  // Main scenarios reached
  c_trip: cover property ($rose(o_alarm_lamp));
  c_clear: cover property ($fell(o_alarm_lamp));
  c_nv: cover property (o_alarm_code == motor_alarm_pkg::CODE_NV);
endmodule : motor_alarm_asserts
bind motor_alarm_supervisor motor_alarm_asserts u_chk (.i_ref_clk, .i_rst, .i_avs_read,
  .i_avs_write, .o_avs_waitrequest, .i_forward_run_input, .i_thermal_open, .o_drive_en,
  .o_brake_release, .o_fault_ok, .o_alarm_lamp, .o_alarm_code, .o_thermal_trip_output);

// ### sim/motor_stand_in.sv
// Stand-in motor: tach pulse train and thermal protector contact
`timescale 1ns/1ps
module motor_stand_in (
  // Clock and commands
  input wire logic i_ref_clk,
  input wire logic [7:0] i_period,
  input wire logic i_hot,
  // Sensor lines
  output logic o_tach_pulse,
  output logic o_thermal_open
);
  logic [7:0] cnt_r = 8'h00;
  // Period counter; zero period means a stopped shaft with a still tach
  always @(posedge i_ref_clk) begin
    cnt_r <= (i_period == 8'h00 || cnt_r + 8'h01 >= i_period) ? 8'h00 : cnt_r + 8'h01;
  end
  assign o_tach_pulse = (i_period != 8'h00) && (cnt_r < 8'h04);
  // Self-returning protector opens only while hot
  assign o_thermal_open = i_hot;
endmodule : motor_stand_in

// ### sim/motor_alarm_supervisor_tb.sv
// Self-checking bench for the motor alarm supervisor
`timescale 1ns/1ps
module motor_alarm_supervisor_tb;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, fore = 1'b0, clr = 1'b0, ext = 1'b1;
  logic back = 1'b0, dir;
  logic free = 1'b0, hot = 1'b0, nv = 1'b0, wt, tach, heat, drv, brk, ast, fok, lamp, cau, th;
  logic [6:0] adr = 7'h00;
  logic [31:0] wd = 32'h0, rdata, rdv;
  logic [7:0] per = 8'h00, code;
  int miscompares = 0, samples_checked = 0;
  // Small tach limits keep speed scenarios short
  motor_alarm_supervisor #(.OVER_CYC(40), .ASSIST_CYC(44), .MS_CYC(10)) DUT (.i_ref_clk(clk),
    .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'h3), .o_avs_readdata(rdata), .o_avs_waitrequest(wt),
    .i_forward_run_input(fore), .i_backward_run_input(back), .i_fault_clear_input(clr),
    .i_outside_fault_input(ext), .i_free_input(free), .i_thermal_open(heat),
    .i_tach_pulse(tach), .i_nv_error(nv), .o_drive_en(drv), .o_drive_dir(dir),
    .o_brake_release(brk), .o_brake_assist(ast), .o_fault_ok(fok), .o_alarm_lamp(lamp),
    .o_alarm_code(code), .o_caution_output(cau), .o_thermal_trip_output(th));
  motor_stand_in u_motor (.i_ref_clk(clk), .i_period(per), .i_hot(hot), .o_tach_pulse(tach),
    .o_thermal_open(heat));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    for (k = 0; k < 50 && wt !== 1'b0; k++) @(posedge clk);
    if (k == 50) miscompares++;
    rdv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_heat;
    bus(1'b1, motor_alarm_pkg::ADDR_CTRL, 32'h19);
    hot <= 1'b1;
    fore <= 1'b1;
    free <= 1'b1;
    cyc(6);
    check("heat code", code, motor_alarm_pkg::CODE_HEAT);
    check("ok lamp drv brk", {fok, lamp, drv, brk}, 4'b0100);
    check("thermal_trip_output", th, 1'b1);
    hot <= 1'b0;
    clr <= 1'b1;
    cyc(6);
    check("thermal_trip_output lamp", {th, lamp}, 2'b01);
    fore <= 1'b0;
    free <= 1'b0;
    clr <= 1'b0;
    cyc(6);
    clr <= 1'b1;
    cyc(6);
    check("cleared", lamp, 1'b0);
    hot <= 1'b1;
    cyc(3);
    hot <= 1'b0;
    cyc(8);
    check("level held", lamp, 1'b1);
    clr <= 1'b0;
  endtask : t_heat
  task automatic t_nv;
    bus(1'b1, motor_alarm_pkg::ADDR_CMD, 32'h3);
    cyc(2);
    check("panel clear", lamp, 1'b0);
    bus(1'b0, motor_alarm_pkg::ADDR_HIST, 32'h0);
    check("hist empty", rdv, 32'h0);
    nv <= 1'b1;
    cyc(3);
    nv <= 1'b0;
    clr <= 1'b1;
    cyc(8);
    check("nv kept", code, motor_alarm_pkg::CODE_NV);
    clr <= 1'b0;
    hot <= 1'b1;
    cyc(3);
    hot <= 1'b0;
    cyc(6);
    bus(1'b0, motor_alarm_pkg::ADDR_HIST, 32'h0);
    check("hist 0", rdv, {24'h0, motor_alarm_pkg::CODE_HEAT});
    bus(1'b0, 7'h24, 32'h0);
    check("hist 1", rdv, {24'h0, motor_alarm_pkg::CODE_NV});
  endtask : t_nv
  task automatic t_ext;
    bus(1'b1, motor_alarm_pkg::ADDR_CMD, 32'h1);
    ext <= 1'b0;
    cyc(6);
    check("unassigned", lamp, 1'b0);
    ext <= 1'b1;
    bus(1'b1, motor_alarm_pkg::ADDR_CTRL, 32'h3);
    ext <= 1'b0;
    cyc(6);
    check("ext code", code, motor_alarm_pkg::CODE_EXT);
    ext <= 1'b1;
    bus(1'b1, motor_alarm_pkg::ADDR_CMD, 32'h1);
  endtask : t_ext
  task automatic t_speed;
    per <= 8'd42;
    cyc(200);
    check("assist only", {ast, lamp}, 2'b10);
    per <= 8'd30;
    cyc(200);
    check("overspeed", code, motor_alarm_pkg::CODE_OVSP);
    per <= 8'h00;
    cyc(100);
    check("assist off", ast, 1'b0);
    bus(1'b1, motor_alarm_pkg::ADDR_CMD, 32'h1);
  endtask : t_speed
  // Stall timing in ms: warning at one second, alarm past the set 1500 ms
  task automatic t_lock;
    bus(1'b1, motor_alarm_pkg::ADDR_LOCK, 32'h05DC);
    fore <= 1'b1;
    cyc(9000);
    check("no warn yet", {cau, lamp, drv}, 3'b001);
    cyc(2000);
    check("warn unassigned", {cau, lamp, drv}, 3'b001);
    bus(1'b0, motor_alarm_pkg::ADDR_STAT, 32'h0);
    check("warn status", rdv[9:8], 2'b11);
    bus(1'b1, motor_alarm_pkg::ADDR_CTRL, 32'h5);
    cyc(4);
    check("caution", cau, 1'b1);
    cyc(5000);
    check("lock code", code, motor_alarm_pkg::CODE_LOCK);
    fore <= 1'b0;
    bus(1'b1, motor_alarm_pkg::ADDR_CMD, 32'h1);
  endtask : t_lock
  task automatic t_por;
    nv <= 1'b1;
    cyc(3);
    nv <= 1'b0;
    fore <= 1'b1;
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(4);
    check("no run at power", drv, 1'b0);
    cyc(6);
    check("run at power", code, motor_alarm_pkg::CODE_POR);
    fore <= 1'b0;
    cyc(6);
    check("run dropped", lamp, 1'b0);
    back <= 1'b1;
    cyc(5);
    check("backward run", {drv, dir, lamp}, 3'b110);
    back <= 1'b0;
  endtask : t_por
  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    cyc(2);
    rst <= 1'b0;
    cyc(6);
    bus(1'b1, motor_alarm_pkg::ADDR_CMD, 32'h2);
    bus(1'b1, 7'h10, 32'hFF);
    bus(1'b0, 7'h10, 32'h0);
    check("unmapped", rdv, 32'h0);
    bus(1'b0, motor_alarm_pkg::ADDR_CTRL, 32'h0);
    check("ctrl reset", rdv, {24'h0, motor_alarm_pkg::CTRL_RST});
    bus(1'b0, motor_alarm_pkg::ADDR_LOCK, 32'h0);
    check("lock reset", rdv, {16'h0, motor_alarm_pkg::LOCK_MS_RST});
    t_heat();
    t_nv();
    t_ext();
    t_speed();
    t_lock();
    t_por();
    conclude();
  end
  initial begin
    #3_000_000;
    miscompares++;
    conclude();
  end
endmodule : motor_alarm_supervisor_tb
